/* src/counter_core.sv */
/*
 * Four-bit synchronous presettable up-counter with ripple carry.
 * Assumes control levels are steady around the rising edge of aclk.
 */
`timescale 1ns/1ps
`default_nettype none

module counter_core (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire counter_pkg::ctrl_t ctrl,
    input  wire logic [3:0]         preset,
    input  wire logic               carry_enable_next,
    output logic      [3:0]         count,
    output logic                    ripple_carry_out
);

    counter_pkg::core_state_t state;
    counter_pkg::core_state_t next_state;

    // ==========================================================
    // Next count: clear beats load beats count beats hold
    always_comb begin
        next_state = state;
        if (!ctrl.clear_n) begin
            next_state.count = counter_pkg::COUNT_ZERO;
        end else if (!ctrl.load_n) begin
            next_state.count = preset;
        end else if (ctrl.pce && ctrl.tce) begin
            next_state.count = state.count + counter_pkg::COUNT_STEP;
        end
        // Carry registered from next values so it tracks count and enable together
        next_state.carry = (next_state.count == counter_pkg::COUNT_MAX) && carry_enable_next;
    end

    // All four bits load on the same edge; inputs matter only here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= counter_pkg::CORE_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign count            = state.count;
    assign ripple_carry_out = state.carry;

    // ==========================================================
    // Checks
    sequence counting_s;
        ctrl.clear_n && ctrl.load_n && ctrl.pce && ctrl.tce;
    endsequence

    chk_clear_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        !ctrl.clear_n |=> count == counter_pkg::COUNT_ZERO) else $error("clear did not zero count");
    chk_clear_over_load: assert property (@(posedge aclk) disable iff (!aresetn)
        (!ctrl.clear_n && !ctrl.load_n) |=> count == counter_pkg::COUNT_ZERO) else $error("load beat clear");
    chk_load_copy: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctrl.clear_n && !ctrl.load_n) |=> count == $past(preset)) else $error("preset not loaded");
    chk_count_step: assert property (@(posedge aclk) disable iff (!aresetn)
        counting_s |=> count == $past(count) + counter_pkg::COUNT_STEP) else $error("count did not step");
    chk_count_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        (counting_s and (count == counter_pkg::COUNT_MAX)) |=> count == counter_pkg::COUNT_ZERO)
        else $error("no wrap from max");
    chk_count_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctrl.clear_n && ctrl.load_n && !(ctrl.pce && ctrl.tce)) |=> $stable(count)) else $error("count moved");
    chk_carry_level: assert property (@(posedge aclk) disable iff (!aresetn)
        ripple_carry_out == ((count == counter_pkg::COUNT_MAX) && ctrl.tce)) else $error("carry wrong");

endmodule

`default_nettype wire

/* src/counter_pkg.sv */
/*
 * Shared constants and types for the four-bit presettable counter and its
 * AXI4-Lite register slave.
 * Assumes a 32-bit data bus with word-aligned registers.
 */
package counter_pkg;

    // ==========================================================
    // Counter geometry
    localparam int unsigned COUNT_WIDTH = 4;
    localparam logic [3:0]  COUNT_ZERO  = 4'h0;
    localparam logic [3:0]  COUNT_STEP  = 4'h1;
    localparam logic [3:0]  COUNT_MAX   = 4'hF;

    // ==========================================================
    // Bus geometry and responses
    localparam int unsigned AXI_ADDR_WIDTH = 12;
    localparam int unsigned AXI_DATA_WIDTH = 32;
    localparam int unsigned AXI_STRB_WIDTH = 4;
    localparam int unsigned BYTE_WIDTH     = 8;
    localparam int unsigned WORD_LSB       = 2;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [11:0] OFFSET_CTRL   = 12'h000;
    localparam logic [11:0] OFFSET_PRESET = 12'h004;
    localparam logic [11:0] OFFSET_STATUS = 12'h008;

    // ==========================================================
    // Field layout: ctrl_t sits in bits 3:0 of CTRL, MSB first
    typedef struct packed {
        logic load_n;
        logic clear_n;
        logic tce;
        logic pce;
    } ctrl_t;

    // Status word: count in 3:0, carry flag above it
    localparam int unsigned STATUS_COUNT_LSB = 0;
    localparam int unsigned STATUS_CARRY_BIT = 4;

    // ==========================================================
    // Counter core state
    typedef struct packed {
        logic [3:0] count;
        logic       carry;
    } core_state_t;

    // ==========================================================
    // Reset values: clear and load idle high, enables off
    localparam ctrl_t       CTRL_RESET   = '{load_n: 1'h1, clear_n: 1'h1, tce: 1'h0, pce: 1'h0};
    localparam logic [3:0]  PRESET_RESET = 4'h0;
    localparam core_state_t CORE_RESET   = '{count: 4'h0, carry: 1'h0};

    // Register selection after address decode
    typedef enum logic [1:0] {
        SEL_CTRL,
        SEL_PRESET,
        SEL_STATUS,
        SEL_NONE
    } reg_sel_t;

endpackage

/* src/counter_top.sv */
/*
 * Top of the presettable binary counter: AXI4-Lite register slave,
 * control and preset registers, and the counter core.
 * Assumes one 200 MHz clock, aclk, and a synchronous active-low aresetn.
 * Assumes an AXI4-Lite master with at most one write and one read open.
 */
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module counter_top #(
    parameter int unsigned ADDR_W = counter_pkg::AXI_ADDR_WIDTH
) (
    input  wire logic                                   aclk,
    input  wire logic                                   aresetn,
    input  wire logic [ADDR_W-1:0]                      awaddr,
    input  wire logic                                   awvalid,
    output logic                                        awready,
    input  wire logic [counter_pkg::AXI_DATA_WIDTH-1:0] wdata,
    input  wire logic [counter_pkg::AXI_STRB_WIDTH-1:0] wstrb,
    input  wire logic                                   wvalid,
    output logic                                        wready,
    output logic [1:0]                                  bresp,
    output logic                                        bvalid,
    input  wire logic                                   bready,
    input  wire logic [ADDR_W-1:0]                      araddr,
    input  wire logic                                   arvalid,
    output logic                                        arready,
    output logic [counter_pkg::AXI_DATA_WIDTH-1:0]      rdata,
    output logic [1:0]                                  rresp,
    output logic                                        rvalid,
    input  wire logic                                   rready,
    output logic [3:0]                                  count_out,
    output logic                                        ripple_carry_out
);

    localparam int unsigned DW = counter_pkg::AXI_DATA_WIDTH;
    localparam int unsigned SW = counter_pkg::AXI_STRB_WIDTH;
    localparam int unsigned CW = counter_pkg::COUNT_WIDTH;

    // ==========================================================
    // Whole state of the slave in one record
    typedef struct packed {
        logic               aw_held;
        logic [ADDR_W-1:0]  aw_addr;
        logic               w_held;
        logic [DW-1:0]      w_data;
        logic [SW-1:0]      w_strb;
        logic               awready;
        logic               wready;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               arready;
        logic               rvalid;
        logic [1:0]         rresp;
        logic [DW-1:0]      rdata;
        counter_pkg::ctrl_t ctrl;
        logic [CW-1:0]      preset;
    } bus_state_t;

    bus_state_t         st;
    bus_state_t         next_st;
    counter_pkg::reg_sel_t wr_sel;
    counter_pkg::reg_sel_t rd_sel;
    logic [DW-1:0]      wr_old;
    logic [DW-1:0]      wr_merged;
    logic [DW-1:0]      rd_word;
    logic [CW-1:0]      core_count;
    logic               core_carry;

    // ==========================================================
    // Address decode, shared by the write and read paths
    function automatic counter_pkg::reg_sel_t reg_decode(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] word;
        word = addr;
        word[counter_pkg::WORD_LSB-1:0] = '0;
        if (word == ADDR_W'(counter_pkg::OFFSET_CTRL)) begin
            reg_decode = counter_pkg::SEL_CTRL;
        end else if (word == ADDR_W'(counter_pkg::OFFSET_PRESET)) begin
            reg_decode = counter_pkg::SEL_PRESET;
        end else if (word == ADDR_W'(counter_pkg::OFFSET_STATUS)) begin
            reg_decode = counter_pkg::SEL_STATUS;
        end else begin
            reg_decode = counter_pkg::SEL_NONE;
        end
    endfunction

    // Readback word of a register; unused bits read as zero
    function automatic logic [DW-1:0] reg_word(
        input counter_pkg::reg_sel_t sel,
        input counter_pkg::ctrl_t    ctrl,
        input logic [CW-1:0]         preset,
        input logic [CW-1:0]         count,
        input logic                  carry
    );
        reg_word = '0;
        case (sel)
            counter_pkg::SEL_CTRL: begin
                reg_word = DW'(ctrl);
            end
            counter_pkg::SEL_PRESET: begin
                reg_word = DW'(preset);
            end
            counter_pkg::SEL_STATUS: begin
                reg_word[counter_pkg::STATUS_COUNT_LSB +: CW] = count;
                reg_word[counter_pkg::STATUS_CARRY_BIT]       = carry;
            end
            default: begin
                reg_word = '0;
            end
        endcase
    endfunction

    assign wr_sel = reg_decode(st.aw_addr);
    assign rd_sel = reg_decode(araddr);
    assign wr_old = reg_word(wr_sel, st.ctrl, st.preset, core_count, core_carry);
    assign rd_word = reg_word(rd_sel, st.ctrl, st.preset, core_count, core_carry);

    // ==========================================================
    // Byte-lane merge so partial writes keep untouched lanes
    wstrb_merge #(
        .LANES (SW)
    ) u_merge (
        .old_word (wr_old),
        .new_word (st.w_data),
        .strb     (st.w_strb),
        .merged   (wr_merged)
    );

    // ==========================================================
    // Next state of the bus slave and the software registers
    always_comb begin
        next_st = st;

        // Address and data are captured independently, in either order
        if (awvalid && st.awready) begin
            next_st.aw_held = 1'h1;
            next_st.aw_addr = awaddr;
        end
        if (wvalid && st.wready) begin
            next_st.w_held = 1'h1;
            next_st.w_data = wdata;
            next_st.w_strb = wstrb;
        end

        // Response leaves once the master has taken it
        if (st.bvalid && bready) begin
            next_st.bvalid = 1'h0;
        end

        // Commit one cycle after both halves are held
        if (st.aw_held && st.w_held && !st.bvalid) begin
            next_st.aw_held = 1'h0;
            next_st.w_held  = 1'h0;
            next_st.bvalid  = 1'h1;
            next_st.bresp   = counter_pkg::RESP_OKAY;
            case (wr_sel)
                counter_pkg::SEL_CTRL: begin
                    // Enables, clear and load are levels the counter samples at each edge
                    next_st.ctrl = counter_pkg::ctrl_t'(wr_merged[$bits(counter_pkg::ctrl_t)-1:0]);
                end
                counter_pkg::SEL_PRESET: begin
                    next_st.preset = wr_merged[CW-1:0];
                end
                counter_pkg::SEL_STATUS: begin
                    // Status is read-only; a write is accepted and dropped
                    next_st.bresp = counter_pkg::RESP_OKAY;
                end
                default: begin
                    next_st.bresp = counter_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Each ready only while its own half is not held and no response is pending, so one write is open at most
        next_st.awready = !next_st.aw_held && !next_st.bvalid;
        next_st.wready  = !next_st.w_held && !next_st.bvalid;

        // Read: data is a snapshot of the address-accept edge
        if (st.rvalid && rready) begin
            next_st.rvalid = 1'h0;
        end
        if (arvalid && st.arready) begin
            next_st.rvalid = 1'h1;
            next_st.rdata  = rd_word;
            if (rd_sel == counter_pkg::SEL_NONE) begin
                next_st.rresp = counter_pkg::RESP_SLVERR;
            end else begin
                next_st.rresp = counter_pkg::RESP_OKAY;
            end
        end
        next_st.arready = !next_st.rvalid;
    end

    // ==========================================================
    // State register with synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st         <= '0;
            st.awready <= 1'h1;
            st.wready  <= 1'h1;
            st.arready <= 1'h1;
            st.ctrl    <= counter_pkg::CTRL_RESET;
            st.preset  <= counter_pkg::PRESET_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Counter core; carry enable taken from the next control value so the
    // registered carry lines up with the control register it depends on
    counter_core u_core (
        .aclk              (aclk),
        .aresetn           (aresetn),
        .ctrl              (st.ctrl),
        .preset            (st.preset),
        .carry_enable_next (next_st.ctrl.tce),
        .count             (core_count),
        .ripple_carry_out  (core_carry)
    );

    // ==========================================================
    // Outputs, all from flip-flops
    assign awready          = st.awready;
    assign wready           = st.wready;
    assign bvalid           = st.bvalid;
    assign bresp            = st.bresp;
    assign arready          = st.arready;
    assign rvalid           = st.rvalid;
    assign rresp            = st.rresp;
    assign rdata            = st.rdata;
    assign count_out        = core_count;
    assign ripple_carry_out = core_carry;

    // ==========================================================
    // Checks on the bus slave and on what software sees
    sequence both_halves_s;
        st.aw_held && st.w_held && !st.bvalid;
    endsequence

    sequence read_taken_s;
        arvalid && arready;
    endsequence

    chk_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        both_halves_s |=> bvalid && !awready && !wready) else $error("write answer missing");
    chk_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (bvalid && !bready) |=> bvalid && $stable(bresp)) else $error("write answer dropped");
    chk_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        read_taken_s |=> rvalid && !arready) else $error("read answer missing");
    chk_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (rvalid && !rready) |=> rvalid && $stable(rdata) && $stable(rresp)) else $error("read answer dropped");
    chk_ctrl_write: assert property (@(posedge aclk) disable iff (!aresetn)
        (both_halves_s and (wr_sel == counter_pkg::SEL_CTRL) and (st.w_strb[0] == 1'h1))
        |=> st.ctrl == counter_pkg::ctrl_t'($past(st.w_data[$bits(counter_pkg::ctrl_t)-1:0])))
        else $error("control not written");
    chk_clear_level: assert property (@(posedge aclk) disable iff (!aresetn)
        (!st.ctrl.clear_n ##1 !st.ctrl.clear_n) |-> count_out == counter_pkg::COUNT_ZERO)
        else $error("count not held at zero under clear");

endmodule

`default_nettype wire

/* src/wstrb_merge.sv */
/*
 * Byte-lane merge of a write word into an old register value.
 * Assumes strobes are one bit per byte lane, lane 0 lowest.
 */
`timescale 1ns/1ps
`default_nettype none

module wstrb_merge #(
    parameter int unsigned LANES = counter_pkg::AXI_STRB_WIDTH
) (
    input  wire logic [counter_pkg::BYTE_WIDTH*LANES-1:0] old_word,
    input  wire logic [counter_pkg::BYTE_WIDTH*LANES-1:0] new_word,
    input  wire logic [LANES-1:0]                         strb,
    output logic      [counter_pkg::BYTE_WIDTH*LANES-1:0] merged
);

    localparam int unsigned BW = counter_pkg::BYTE_WIDTH;

    // ==========================================================
    // One mux per lane; unstrobed lanes keep the old bits
    genvar lane;
    generate
        for (lane = 0; lane < LANES; lane++) begin : g_lane
            assign merged[BW*lane +: BW] = strb[lane] ? new_word[BW*lane +: BW] : old_word[BW*lane +: BW];
        end
    endgenerate

endmodule

`default_nettype wire

/* testbench/far_stage.sv */
/*
 * Behavioural model of a cascaded upper counter stage.
 * Assumes it shares aclk and aresetn with the block and sees its carry.
 */
`timescale 1ns/1ps
`default_nettype none

module far_stage (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       pce,
    input  wire logic       ripple_carry_out,
    output logic      [3:0] upper
);
    // ==========================================================
    // Upper nibble
    // Gated by its own pce: it steps only when pce and the carry are both high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            upper <= 4'h0;
        end else if (pce && ripple_carry_out) begin
            upper <= upper + 4'h1;
        end
    end
endmodule

`default_nettype wire

/* testbench/tb_top.sv */
/*
 * Self-checking bench for the register-driven presettable counter.
 * Assumes counter_top and counter_pkg are compiled first, 200 MHz aclk.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    typedef struct packed {
        logic [3:0] preset;
        logic [3:0] ctrl;
        logic       incr;
        logic       zero;
    } row_t;

    logic        aclk    = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] awaddr  = 12'h000;
    logic        awvalid = 1'b0;
    logic [31:0] wdata   = 32'h0000_0000;
    logic [3:0]  wstrb   = 4'hF;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic [11:0] araddr  = 12'h000;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, ripple_carry_out;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, rd;
    logic [3:0]  count_out, cnt_mid, upper, exp, exp_up;
    logic [1:0]  rsp;
    logic        tce_sh  = 1'b0;
    logic        pce_sh  = 1'b0;
    int          err_total  = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          e1, n;
    // Plain rows: preset, control word, counts or not, clears or not
    row_t        rows [6] = '{'{4'hD, 4'hF, 1'b1, 1'b0}, '{4'h3, 4'hD, 1'b0, 1'b0},
                              '{4'hF, 4'hE, 1'b0, 1'b0}, '{4'h6, 4'h7, 1'b0, 1'b0},
                              '{4'h9, 4'h3, 1'b0, 1'b1}, '{4'hA, 4'hB, 1'b0, 1'b1}};

    // ==========================================================
    // Clock, edge counter and instances
    always #2.5 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;

    counter_top #(.ADDR_W(12)) DUT (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .count_out(count_out),
        .ripple_carry_out(ripple_carry_out)
    );

    far_stage partner (
        .aclk(aclk), .aresetn(aresetn), .pce(pce_sh), .ripple_carry_out(ripple_carry_out), .upper(upper)
    );

    // ==========================================================
    // Comparison, verdict and watchdog
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge aclk);
        err_total++;
        $display("Error at %0t: watchdog expired", $time);
        summarize();
    end

    // ==========================================================
    // Bus master tasks: each channel released at its own handshake edge
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_open;
        logic w_open;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_open = 1'b1;
        w_open = 1'b1;
        forever begin
            @(posedge aclk);
            // Control lands one edge after the later half is taken; shadows follow there
            if (!aw_open && !w_open && a == counter_pkg::OFFSET_CTRL) begin
                tce_sh <= d[1];
                pce_sh <= d[0];
            end
            if (awready) begin
                awvalid <= 1'b0;
                aw_open = 1'b0;
            end
            if (wready) begin
                wvalid <= 1'b0;
                w_open = 1'b0;
            end
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            // Take the answer only at an edge where rready was already up
            if (rvalid && rready) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
            // Ready comes a cycle late, so the slave must hold its answer
            if (arready) begin
                arvalid <= 1'b0;
            end else if (!arvalid) begin
                rready <= 1'b1;
            end
        end
    endtask

    task automatic put(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        check(r, counter_pkg::RESP_OKAY);
    endtask

    // ==========================================================
    // Continuous watch: count moves only at the edge, carry tracks count
    always @(posedge aclk) begin
        #1 cnt_mid = count_out;
    end

    always @(negedge aclk) begin
        if (aresetn) begin
            check(count_out, cnt_mid);
            check(ripple_carry_out, count_out == counter_pkg::COUNT_MAX && tce_sh);
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        exp_up = 4'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(counter_pkg::OFFSET_CTRL, rd, rsp);
        check(rd, 32'h0000_000C);
        axi_rd(counter_pkg::OFFSET_PRESET, rd, rsp);
        check(rd, 32'h0000_0000);
        check(count_out, 4'h0);
        // Each row: load its preset, apply its control word for six edges
        for (int i = 0; i < 6; i++) begin
            put(counter_pkg::OFFSET_PRESET, {28'h0, rows[i].preset});
            put(counter_pkg::OFFSET_CTRL, 32'h0000_0004);
            put(counter_pkg::OFFSET_CTRL, {28'h0, rows[i].ctrl});
            e1 = cyc;
            repeat (5) @(posedge aclk);
            @(negedge aclk);
            n = cyc - e1;
            exp = rows[i].zero ? 4'h0 : rows[i].preset + (rows[i].incr ? n[3:0] : 4'h0);
            check(count_out, exp);
            if (rows[i].incr) exp_up = exp_up + 4'((rows[i].preset + n) >> 4);
            check(upper, exp_up);
            put(counter_pkg::OFFSET_CTRL, 32'h0000_000C);
        end
        // Top preset held with trickle enable: carry shows in status
        put(counter_pkg::OFFSET_PRESET, 32'h0000_000F);
        put(counter_pkg::OFFSET_CTRL, 32'h0000_0004);
        put(counter_pkg::OFFSET_CTRL, 32'h0000_000E);
        axi_rd(counter_pkg::OFFSET_STATUS, rd, rsp);
        check(rd, 32'h0000_001F);
        put(counter_pkg::OFFSET_STATUS, 32'h0000_0003);
        axi_rd(counter_pkg::OFFSET_CTRL, rd, rsp);
        check(rd, 32'h0000_000E);
        // Unmapped place refuses both ways
        axi_wr(12'h010, 32'h0000_0000, rsp);
        check(rsp, counter_pkg::RESP_SLVERR);
        axi_rd(12'h010, rd, rsp);
        check(rsp, counter_pkg::RESP_SLVERR);
        check(rd, 32'h0000_0000);
        // Short cycle: outside logic decodes a terminal count and clears
        put(counter_pkg::OFFSET_PRESET, 32'h0000_000D);
        put(counter_pkg::OFFSET_CTRL, 32'h0000_0004);
        put(counter_pkg::OFFSET_CTRL, 32'h0000_000F);
        for (n = 0; n < 20 && count_out != 4'h2; n++) begin
            @(negedge aclk);
        end
        check(count_out, 4'h2);
        put(counter_pkg::OFFSET_CTRL, 32'h0000_000B);
        @(negedge aclk);
        check(count_out, 4'h0);
        // Reset in mid-count returns everything to idle
        put(counter_pkg::OFFSET_CTRL, 32'h0000_000F);
        repeat (4) @(posedge aclk);
        aresetn <= 1'b0;
        tce_sh <= 1'b0;
        pce_sh <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        check(count_out, 4'h0);
        check(ripple_carry_out, 1'b0);
        check({awready, wready, arready, bvalid, rvalid}, 5'h1C);
        axi_rd(counter_pkg::OFFSET_CTRL, rd, rsp);
        check(rd, 32'h0000_000C);
        summarize();
    end
endmodule

`default_nettype wire
